// *** event_capture.sv ***
// Event capture, fail-safe detectors and wake signalling on RXD and regulator switch
`timescale 1ns/1ps
module event_capture #(
  parameter int EVT_DELAY_CYCLES   = event_capture_pkg::EVT_DELAY_CYCLES,
  parameter int SILENCE_CYCLES     = event_capture_pkg::SILENCE_CYCLES,
  parameter int DOM_TIMEOUT_CYCLES = event_capture_pkg::DOM_TIMEOUT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [1:0] transceiver_mode_code,
  input  wire logic [2:0] device_mode_code,
  input  wire logic       sleep_request,
  output logic            sleep_granted,
  output logic            sleep_refused,
  output logic            wake_to_standby,
  input  wire logic       power_restored,
  input  wire logic       vio_present,
  input  wire logic       vcc_undervoltage,
  input  wire logic       thermal_prewarn,
  input  wire logic       thermal_shutdown,
  input  wire logic       bus_comparator,
  input  wire logic       rxd_level,
  input  wire logic       txd_level,
  input  wire logic       txd_dom_timeout,
  input  wire logic       remote_wake,
  input  wire logic       wake_pin,
  input  wire logic       selective_frame_error_event,
  input  wire logic [2:0] spi_errors,
  output logic            transmitter_enable,
  output logic            receiver_enable,
  output logic            rxd_event_low,
  output logic            regulator_switch_output
);
  typedef enum logic [2:0] {
    RXD_IDLE  = 3'b001,
    RXD_LOW   = 3'b010,
    RXD_DELAY = 3'b100
  } rxd_state_type;

  // ---------------------------------------------------------------
  // Reset synchroniser
  // ---------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  // Flops below leave reset two edges after rst_n rises, never on the raw edge
  wire rst_ok_n = rst_sync_q;

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  wire in_sleep   = (device_mode_code == event_capture_pkg::DEV_MODE_SLEEP);
  wire in_stby    = (device_mode_code == event_capture_pkg::DEV_MODE_STBY);
  wire dev_normal = (device_mode_code == event_capture_pkg::DEV_MODE_NORMAL);
  wire trx_active = (transceiver_mode_code == event_capture_pkg::TRX_MODE_ACTIVE);
  wire trx_normal = (transceiver_mode_code == event_capture_pkg::TRX_MODE_NORMAL);
  // Device normal mode without thermal shutdown enables the transmitter and clamp detection
  wire trx_listen = dev_normal && !thermal_shutdown;

  // ---------------------------------------------------------------
  // Enable registers
  // ---------------------------------------------------------------
  logic [7:0] sys_en_q;
  logic [7:0] trx_en_q;
  logic [7:0] trx_en2_q;
  logic [7:0] wake_en_q;
  wire wr_sys_en  = reg_wr && (reg_addr == event_capture_pkg::ADDR_SYS_EN);
  wire wr_trx_en  = reg_wr && (reg_addr == event_capture_pkg::ADDR_TRX_EN);
  wire wr_trx_en2 = reg_wr && (reg_addr == event_capture_pkg::ADDR_TRX_EN2);
  wire wr_wake_en = reg_wr && (reg_addr == event_capture_pkg::ADDR_WAKE_EN);
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      sys_en_q  <= event_capture_pkg::RESET_BYTE;
      trx_en_q  <= event_capture_pkg::RESET_BYTE;
      trx_en2_q <= event_capture_pkg::RESET_BYTE;
      wake_en_q <= event_capture_pkg::RESET_BYTE;
    end else begin
      if (wr_sys_en)  sys_en_q  <= reg_wdata & 8'h26;
      if (wr_trx_en)  trx_en_q  <= reg_wdata & 8'h31;
      if (wr_trx_en2) trx_en2_q <= reg_wdata & 8'h01;
      if (wr_wake_en) wake_en_q <= reg_wdata & 8'h03;
    end
  end

  // ---------------------------------------------------------------
  // Detectors
  // ---------------------------------------------------------------
  logic [7:0]  clamp_cnt_q;
  logic        rxd_clamp_q;
  logic        prev_wake_q;
  logic        prev_bus_q;
  logic        prev_txd_q;
  logic        prev_power_q;
  logic [31:0] sil_cnt_q;
  logic [31:0] dom_cnt_q;
  logic [2:0]  rec_cnt_q;
  logic        dom_flag_q;
  logic        rec_flag_q;
  logic        uv_q;

  wire clamp_seen  = bus_comparator && rxd_level && trx_listen;
  wire clamp_reset = in_sleep || in_stby || !rxd_level;
  wire clamp_hit   = clamp_seen && (clamp_cnt_q == 8'(event_capture_pkg::CLAMP_CYCLES));
  wire bus_edge    = bus_comparator != prev_bus_q;
  wire txd_edge    = txd_level != prev_txd_q;
  // Recessive clamp: transmitter drove dominant but bus stayed recessive
  wire rec_cycle   = !prev_txd_q && txd_level && !bus_comparator;
  wire sil_hit     = (sil_cnt_q == 32'(SILENCE_CYCLES));
  wire dom_hit     = (dom_cnt_q == 32'(DOM_TIMEOUT_CYCLES)) && !in_sleep;
  wire rec_hit     = (rec_cnt_q == 3'(event_capture_pkg::REC_CLAMP_CYCLES)) && !in_sleep;

  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      clamp_cnt_q  <= 8'h00;
      rxd_clamp_q  <= 1'b0;
      prev_wake_q  <= 1'b0;
      prev_bus_q   <= 1'b0;
      prev_txd_q   <= 1'b1;
      prev_power_q <= 1'b0;
      sil_cnt_q    <= 32'h0000_0000;
      dom_cnt_q    <= 32'h0000_0000;
      rec_cnt_q    <= 3'h0;
      dom_flag_q   <= 1'b0;
      rec_flag_q   <= 1'b0;
      uv_q         <= 1'b0;
    end else begin
      prev_wake_q  <= wake_pin;
      prev_bus_q   <= bus_comparator;
      prev_txd_q   <= txd_level;
      prev_power_q <= power_restored;
      uv_q         <= vcc_undervoltage && trx_active;
      if (!clamp_seen)
        clamp_cnt_q <= 8'h00;
      else if (!clamp_hit)
        clamp_cnt_q <= clamp_cnt_q + 8'h01;
      if (clamp_reset)
        rxd_clamp_q <= 1'b0;
      else if (clamp_hit)
        rxd_clamp_q <= 1'b1;
      if (bus_edge || sil_hit)
        sil_cnt_q <= 32'h0000_0000;
      else
        sil_cnt_q <= sil_cnt_q + 32'h0000_0001;
      if (bus_edge || txd_edge || !bus_comparator || !txd_level || dom_hit)
        dom_cnt_q <= 32'h0000_0000;
      else
        dom_cnt_q <= dom_cnt_q + 32'h0000_0001;
      dom_flag_q <= bus_comparator && (dom_flag_q || dom_hit);
      if (bus_comparator || rec_hit)
        rec_cnt_q <= 3'h0;
      else if (rec_cycle)
        rec_cnt_q <= rec_cnt_q + 3'h1;
      rec_flag_q <= !bus_comparator && (rec_flag_q || rec_hit);
    end
  end

  // ---------------------------------------------------------------
  // Event sources, gated by enables except power-up, frame error and bus failure
  // ---------------------------------------------------------------
  wire wake_ok  = !thermal_shutdown;
  wire wk_rise  = wake_ok && wake_pin && !prev_wake_q && wake_en_q[event_capture_pkg::WK_RISE];
  wire wk_fall  = wake_ok && !wake_pin && prev_wake_q && wake_en_q[event_capture_pkg::WK_FALL];
  wire rwake    = wake_ok && remote_wake && trx_en_q[event_capture_pkg::TRX_RWAKE];
  wire fail_en  = trx_en_q[event_capture_pkg::TRX_FAIL];
  wire clamp_ev = clamp_hit && !rxd_clamp_q && fail_en && trx_en2_q[0];
  wire trx_fail = !in_sleep && fail_en &&
                  (txd_dom_timeout || (vcc_undervoltage && trx_active) ) ;
  wire prew_ev  = thermal_prewarn && dev_normal && sys_en_q[event_capture_pkg::SYS_PREW];
  wire spi_ev   = !in_sleep && (spi_errors != event_capture_pkg::SPI_ERR_NONE) &&
                  sys_en_q[event_capture_pkg::SYS_SPI];
  wire pwr_ev   = power_restored && !prev_power_q;
  wire sil_ev   = sil_hit && trx_en_q[event_capture_pkg::TRX_SIL];

  wire [7:0] sys_set  = {3'b000, pwr_ev, 1'b0, prew_ev, spi_ev,
                         selective_frame_error_event};
  wire [7:0] trx_set  = {2'b00, sil_ev, trx_fail || clamp_ev, 3'b000, rwake};
  wire [7:0] bus_set  = {6'b000000, dom_hit, rec_hit};
  wire [7:0] wake_set = {6'b000000, wk_rise, wk_fall};

  // ---------------------------------------------------------------
  // Sticky status, write one to clear, set wins, except prew_st_q which tracks thermal_prewarn each cycle
  // ---------------------------------------------------------------
  logic [7:0] sys_st_q;
  logic [7:0] trx_st_q;
  logic [7:0] bus_st_q;
  logic [7:0] wake_st_q;
  logic       prew_st_q;

  function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] set,
                                        input logic wr, input logic [7:0] data);
    sticky = (cur & ~(wr ? data : 8'h00)) | set;
  endfunction

  wire clr_sys  = reg_wr && (reg_addr == event_capture_pkg::ADDR_SYS_STAT);
  wire clr_trx  = reg_wr && (reg_addr == event_capture_pkg::ADDR_TRX_ESTAT);
  wire clr_bus  = reg_wr && (reg_addr == event_capture_pkg::ADDR_BUS_ESTAT);
  wire clr_wake = reg_wr && (reg_addr == event_capture_pkg::ADDR_WAKE_STAT);
  wire any_clear = (clr_sys || clr_trx || clr_bus || clr_wake) && (reg_wdata != 8'h00);

  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      sys_st_q  <= event_capture_pkg::RESET_BYTE;
      trx_st_q  <= event_capture_pkg::RESET_BYTE;
      bus_st_q  <= event_capture_pkg::RESET_BYTE;
      wake_st_q <= event_capture_pkg::RESET_BYTE;
      prew_st_q <= 1'b0;
    end else begin
      sys_st_q  <= sticky(sys_st_q, sys_set, clr_sys, reg_wdata);
      trx_st_q  <= sticky(trx_st_q, trx_set, clr_trx, reg_wdata);
      bus_st_q  <= sticky(bus_st_q, bus_set, clr_bus, reg_wdata);
      wake_st_q <= sticky(wake_st_q, wake_set, clr_wake, reg_wdata);
      prew_st_q <= thermal_prewarn;
    end
  end

  // Interrupt-worthy pending: prewarning only counts with transceiver normal
  wire [7:0] sys_pend = sys_st_q & ~(trx_normal ? 8'h00 :
                        (8'h01 << event_capture_pkg::SYS_PREW));
  wire pending = (|sys_pend) || (|trx_st_q) || (|bus_st_q) || (|wake_st_q);
  wire any_set = (|sys_set) || (|trx_set) || (|bus_set) || (|wake_set);

  // ---------------------------------------------------------------
  // RXD signalling with event delay
  // ---------------------------------------------------------------
  rxd_state_type rxd_state_q;
  rxd_state_type rxd_state_d;
  logic [31:0]   delay_cnt_q;
  wire delay_done = (delay_cnt_q == 32'(EVT_DELAY_CYCLES));
  always_comb begin
    rxd_state_d = rxd_state_q;
    case (rxd_state_q)
      RXD_IDLE:  if (pending) rxd_state_d = RXD_LOW;
      RXD_LOW:   if (any_clear) rxd_state_d = RXD_DELAY;
      RXD_DELAY: if (delay_done) rxd_state_d = pending ? RXD_LOW : RXD_IDLE;
      default:   rxd_state_d = RXD_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      rxd_state_q <= RXD_IDLE;
      delay_cnt_q <= 32'h0000_0000;
    end else begin
      rxd_state_q <= rxd_state_d;
      delay_cnt_q <= (rxd_state_q == RXD_DELAY) ? delay_cnt_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Sleep handling and outputs
  // ---------------------------------------------------------------
  wire wake_src_on = trx_en_q[event_capture_pkg::TRX_RWAKE] || (|wake_en_q);
  wire any_status  = (|sys_st_q) || (|trx_st_q) || (|bus_st_q) || (|wake_st_q);
  wire sleep_ok    = wake_src_on && !any_status && !any_set;
  logic regsw_q;
  logic wake_stby_q;
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      regsw_q     <= 1'b1;
      wake_stby_q <= 1'b0;
    end else begin
      wake_stby_q <= in_sleep && any_set;
      if (in_sleep && any_set)
        regsw_q <= 1'b1;
      else if (sleep_request && sleep_ok)
        regsw_q <= 1'b0;
    end
  end

  assign sleep_granted           = sleep_request && sleep_ok;
  assign sleep_refused           = sleep_request && !sleep_ok;
  assign wake_to_standby         = wake_stby_q;
  assign regulator_switch_output = regsw_q;
  // Held low across overtemp so a pending wake is not lost
  assign rxd_event_low           = vio_present && (rxd_state_q == RXD_LOW) &&
                                   !(dev_normal && !thermal_shutdown);
  assign transmitter_enable      = trx_listen && !rxd_clamp_q && !txd_dom_timeout;
  assign receiver_enable         = !thermal_shutdown && !in_sleep;

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  wire [7:0] trx_status = {transmitter_enable, 4'h0, prew_st_q, uv_q, 1'b0};
  wire [7:0] summary    = {4'h0, |wake_st_q, |bus_st_q, |trx_st_q, |sys_st_q};
  wire [7:0] rd_mux =
    (reg_addr == event_capture_pkg::ADDR_SYS_EN)    ? sys_en_q   :
    (reg_addr == event_capture_pkg::ADDR_TRX_STAT)  ? trx_status :
    (reg_addr == event_capture_pkg::ADDR_TRX_EN)    ? trx_en_q   :
    (reg_addr == event_capture_pkg::ADDR_BUS_IND)   ? {6'h00, dom_flag_q, rec_flag_q} :
    (reg_addr == event_capture_pkg::ADDR_TRX_EN2)   ? trx_en2_q  :
    (reg_addr == event_capture_pkg::ADDR_TRX_STAT2) ? {7'h00, rxd_clamp_q} :
    (reg_addr == event_capture_pkg::ADDR_WAKE_EN)   ? wake_en_q  :
    (reg_addr == event_capture_pkg::ADDR_SUMMARY)   ? summary    :
    (reg_addr == event_capture_pkg::ADDR_SYS_STAT)  ? sys_st_q   :
    (reg_addr == event_capture_pkg::ADDR_TRX_ESTAT) ? trx_st_q   :
    (reg_addr == event_capture_pkg::ADDR_BUS_ESTAT) ? bus_st_q   :
    (reg_addr == event_capture_pkg::ADDR_WAKE_STAT) ? wake_st_q  : 8'h00;
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end
endmodule

// *** event_capture_pkg.sv ***
// Package: register map, field positions, reset values and timing for the event capture block
package event_capture_pkg;
  localparam logic [6:0] ADDR_SYS_EN    = 7'h04;
  localparam logic [6:0] ADDR_TRX_STAT  = 7'h22;
  localparam logic [6:0] ADDR_TRX_EN    = 7'h23;
  localparam logic [6:0] ADDR_BUS_IND   = 7'h33;
  localparam logic [6:0] ADDR_TRX_EN2   = 7'h34;
  localparam logic [6:0] ADDR_TRX_STAT2 = 7'h35;
  localparam logic [6:0] ADDR_WAKE_EN   = 7'h4c;
  localparam logic [6:0] ADDR_SUMMARY   = 7'h60;
  localparam logic [6:0] ADDR_SYS_STAT  = 7'h61;
  localparam logic [6:0] ADDR_TRX_ESTAT = 7'h63;
  localparam logic [6:0] ADDR_BUS_ESTAT = 7'h65;
  localparam logic [6:0] ADDR_WAKE_STAT = 7'h64;
  // System event bits
  localparam int SYS_PWRUP = 4;
  localparam int SYS_PREW  = 2;
  localparam int SYS_SPI   = 1;
  localparam int SYS_FRERR = 0;
  // Transceiver event bits
  localparam int TRX_SIL   = 5;
  localparam int TRX_FAIL  = 4;
  localparam int TRX_RWAKE = 0;
  // Bus failure event bits
  localparam int BUS_DOM   = 1;
  localparam int BUS_REC   = 0;
  // Wake pin bits
  localparam int WK_RISE   = 1;
  localparam int WK_FALL   = 0;
  // Transceiver status bits
  localparam int TS_TXON   = 7;
  localparam int TS_PREW   = 2;
  localparam int TS_UV     = 1;
  // Summary bits
  localparam int SUM_WAKE  = 3;
  localparam int SUM_BUS   = 2;
  localparam int SUM_TRX   = 1;
  localparam int SUM_SYS   = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] TRX_MODE_ACTIVE = 2'b01;
  localparam logic [1:0] TRX_MODE_NORMAL = 2'b00;
  localparam logic [2:0] DEV_MODE_NORMAL = 3'b111;
  localparam logic [2:0] DEV_MODE_SLEEP  = 3'b001;
  localparam logic [2:0] DEV_MODE_STBY   = 3'b100;
  localparam int REC_CLAMP_CYCLES = 4;
  localparam int CLK_MHZ = 25;
  localparam int CLAMP_TIME_NS = 90;
  localparam int CLAMP_CYCLES = (CLAMP_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int EVT_DELAY_US = 1000;
  localparam int EVT_DELAY_CYCLES = EVT_DELAY_US * CLK_MHZ;
  localparam int SILENCE_US = 1000000;
  localparam int SILENCE_CYCLES = SILENCE_US * CLK_MHZ;
  localparam int DOM_TIMEOUT_US = 2000;
  localparam int DOM_TIMEOUT_CYCLES = DOM_TIMEOUT_US * CLK_MHZ;
  localparam logic [2:0] SPI_ERR_NONE = 3'b000;
endpackage

// *** event_capture_sva.sv ***
// Checker: port-level timing properties of the event capture block
`timescale 1ns/1ps
module event_capture_sva (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [2:0] device_mode_code,
  input wire logic       sleep_request,
  input wire logic       sleep_granted,
  input wire logic       sleep_refused,
  input wire logic       wake_to_standby,
  input wire logic       power_restored,
  input wire logic       vio_present,
  input wire logic       thermal_shutdown,
  input wire logic       transmitter_enable,
  input wire logic       receiver_enable,
  input wire logic       rxd_event_low
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic clr_wr;
  assign clr_wr = reg_wr && (reg_wdata != 8'h00) &&
                  (reg_addr inside {7'h61, 7'h63, 7'h64, 7'h65});
  // ------
  // Properties
  // ------
  property p_sleep_excl; !(sleep_granted && sleep_refused); endproperty
  property p_grant_req; sleep_granted |-> sleep_request; endproperty
  property p_refuse_pend; sleep_request && rxd_event_low |-> sleep_refused; endproperty
  property p_shut_off;
    thermal_shutdown |-> ##[0:2] !(transmitter_enable || receiver_enable);
  endproperty
  property p_hot_no_wake;
    thermal_shutdown && $past(thermal_shutdown, 2) |-> !wake_to_standby;
  endproperty
  property p_wake_src; wake_to_standby |-> $past(device_mode_code) == 3'b001; endproperty
  property p_wake_pulse; wake_to_standby |=> !wake_to_standby; endproperty
  property p_clear_release; rxd_event_low && clr_wr |=> !rxd_event_low; endproperty
  // Holdoff keeps the host from being hit once per event
  property p_relow_delay;
    $fell(rxd_event_low) && device_mode_code != 3'b111 |=> !rxd_event_low [*8];
  endproperty
  property p_pwr_flag;
    $rose(power_restored) && vio_present && device_mode_code == 3'b100
      |-> ##[1:4] rxd_event_low;
  endproperty
  a_sleep_excl: assert property (p_sleep_excl) else $error("grant and refuse together");
  a_grant_req: assert property (p_grant_req) else $error("grant without request");
  a_refuse_pend: assert property (p_refuse_pend) else $error("sleep with event");
  a_shut_off: assert property (p_shut_off) else $error("transceiver on when hot");
  a_hot_no_wake: assert property (p_hot_no_wake) else $error("wake when hot");
  a_wake_src: assert property (p_wake_src) else $error("standby wake not from sleep");
  a_wake_pulse: assert property (p_wake_pulse) else $error("standby wake too long");
  a_clear_release: assert property (p_clear_release) else $error("rxd not released");
  a_relow_delay: assert property (p_relow_delay) else $error("rxd relow too soon");
  a_pwr_flag: assert property (p_pwr_flag) else $error("power-up not flagged");
  c_wake: cover property (wake_to_standby);
  c_grant: cover property (sleep_granted);
  c_refuse: cover property (sleep_refused);
  c_release: cover property ($fell(rxd_event_low));
endmodule

// *** event_host_model.sv ***
// Host controller model: register accesses on the block's strobes
`timescale 1ns/1ps
module event_host_model (
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [6:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
  end
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // Released data inverted so a stale byte never looks valid
    reg_wdata = ~d;
  endtask
  task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  // Write back only what was seen, so late events survive
  task automatic clear_seen(input logic [6:0] a, output logic [7:0] seen);
    read_reg(a, seen);
    write_reg(a, seen);
  endtask
endmodule

// *** test_event_capture.sv ***
// Testbench: register-level scenarios for the event capture block
`timescale 1ns/1ps
module test_event_capture;
  localparam int EVT = 20;
  logic       clk, rst_n, reg_wr, reg_rd, slp_req, granted, refused, w2s, w2s_seen;
  logic       pwr, vio, uv, prew, shut, bus_dom, rxd_rec, txd_rec, txd_to;
  logic       rwake, wpin, frerr, tx_en, rx_en, rxd_low, regsw;
  logic [1:0] tm;
  logic [2:0] dm, spi_err;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [6:0] en_a [4] = '{7'h04, 7'h23, 7'h34, 7'h4c};
  logic [7:0] en_m [4] = '{8'h26, 8'h31, 8'h01, 8'h03};
  int         miscompares = 0;
  int         check_count = 0;
  int         cycles = 0;
  event_capture #(.EVT_DELAY_CYCLES(EVT), .SILENCE_CYCLES(50000),
    .DOM_TIMEOUT_CYCLES(40)) event_capture_i (
    .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .transceiver_mode_code(tm),
    .device_mode_code(dm), .sleep_request(slp_req), .sleep_granted(granted),
    .sleep_refused(refused), .wake_to_standby(w2s), .power_restored(pwr),
    .vio_present(vio), .vcc_undervoltage(uv), .thermal_prewarn(prew),
    .thermal_shutdown(shut), .bus_comparator(bus_dom), .rxd_level(rxd_rec),
    .txd_level(txd_rec), .txd_dom_timeout(txd_to), .remote_wake(rwake), .wake_pin(wpin),
    .selective_frame_error_event(frerr), .spi_errors(spi_err), .transmitter_enable(tx_en),
    .receiver_enable(rx_en), .rxd_event_low(rxd_low), .regulator_switch_output(regsw));
  event_host_model event_host_model_i (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  always #20 clk = ~clk;
  always @(negedge clk) if (w2s === 1'b1) w2s_seen <= 1'b1;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test;
    end
  end
  task automatic check_reg(input logic [6:0] a, input logic [7:0] got, input logic [7:0] e);
    check_count++;
    if (got !== e) begin
      miscompares++;
      $display("Error reg %h expected %h seen %h", a, e, got);
    end
  endtask
  task automatic check_bit(input string n, input logic got, input logic e);
    check_count++;
    if (got !== e) begin
      miscompares++;
      $display("Error %s expected %b seen %b", n, e, got);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    event_host_model_i.read_reg(a, d);
    check_reg(a, d & m, e);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    event_host_model_i.write_reg(a, d);
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic sleep_try(input logic g);
    @(negedge clk);
    slp_req = 1'b1;
    #1;
    check_bit("sleep_granted", granted, g);
    check_bit("sleep_refused", refused, !g);
    @(negedge clk);
    slp_req = 1'b0;
  endtask
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ------
  // Scenarios
  // ------
  initial begin
    clk = 1'b0; rst_n = 1'b0; w2s_seen = 1'b0; slp_req = 1'b0; tm = 2'b10; dm = 3'b100;
    pwr = 1'b0; vio = 1'b1; uv = 1'b0; prew = 1'b0; shut = 1'b0; bus_dom = 1'b0;
    rxd_rec = 1'b1; txd_rec = 1'b1; txd_to = 1'b0; rwake = 1'b0; wpin = 1'b0;
    frerr = 1'b0; spi_err = 3'b000;
    wt(8);
    rst_n = 1'b1;
    wt(3);
    check_bit("regulator_switch_output", regsw, 1'b1);
    check_bit("rxd_event_low", rxd_low, 1'b0);
    foreach (en_a[i]) rd(en_a[i], 8'hff, 8'h00);
    sleep_try(1'b0);
    dm = 3'b111; tm = 2'b00; prew = 1'b1; wt(4);
    rd(7'h22, 8'h04, 8'h04);
    rd(7'h61, 8'hff, 8'h00);
    prew = 1'b0; dm = 3'b100; tm = 2'b10;
    $display("Test reset and prewarn status done");
    pwr = 1'b1; wt(4);
    check_bit("rxd_event_low", rxd_low, 1'b1);
    rd(7'h61, 8'hff, 8'h10);
    rd(7'h60, 8'h0f, 8'h01);
    wr(7'h61, 8'h00);
    rd(7'h61, 8'hff, 8'h10);
    frerr = 1'b1; wt(1); frerr = 1'b0; wt(3);
    event_host_model_i.clear_seen(7'h61, v);
    check_reg(7'h61, v, 8'h11);
    check_bit("rxd_event_low", rxd_low, 1'b0);
    rd(7'h61, 8'hff, 8'h00);
    wt(EVT + 4);
    check_bit("rxd_event_low", rxd_low, 1'b0);
    $display("Test power-up event done");
    foreach (en_a[i]) begin
      wr(en_a[i], 8'hff);
      rd(en_a[i], 8'hff, en_m[i]);
    end
    wr(7'h23, 8'h11);
    wr(7'h60, 8'hff); rd(7'h60, 8'hff, 8'h00);
    wr(7'h10, 8'hff); rd(7'h10, 8'hff, 8'h00);
    sleep_try(1'b1);
    check_bit("regulator_switch_output", regsw, 1'b0);
    wpin = 1'b1; wt(4);
    check_bit("rxd_event_low", rxd_low, 1'b1);
    rd(7'h64, 8'hff, 8'h02);
    rd(7'h60, 8'h0f, 8'h08);
    sleep_try(1'b0);
    wpin = 1'b0; wt(4);
    rd(7'h64, 8'hff, 8'h03);
    wr(7'h64, 8'h02);
    check_bit("rxd_event_low", rxd_low, 1'b0);
    rd(7'h64, 8'hff, 8'h01);
    wt(EVT);
    check_bit("rxd_event_low", rxd_low, 1'b1);
    wr(7'h64, 8'h01); wt(EVT + 4);
    check_bit("rxd_event_low", rxd_low, 1'b0);
    $display("Test wake pin and holdoff done");
    tm = 2'b01; uv = 1'b1; wt(4);
    rd(7'h22, 8'h02, 8'h02);
    rd(7'h63, 8'h10, 8'h10);
    uv = 1'b0; tm = 2'b10;
    event_host_model_i.clear_seen(7'h63, v); wt(EVT + 4);
    dm = 3'b111; tm = 2'b00; bus_dom = 1'b1; wt(6);
    check_bit("transmitter_enable", tx_en, 1'b0);
    rd(7'h35, 8'h01, 8'h01);
    rd(7'h22, 8'h80, 8'h00);
    rd(7'h63, 8'h10, 8'h10);
    rxd_rec = 1'b0; wt(2);
    check_bit("transmitter_enable", tx_en, 1'b1);
    bus_dom = 1'b0; rxd_rec = 1'b1;
    event_host_model_i.clear_seen(7'h63, v);
    prew = 1'b1; wt(4);
    rd(7'h61, 8'h04, 8'h04);
    prew = 1'b0;
    event_host_model_i.clear_seen(7'h61, v);
    dm = 3'b100; tm = 2'b10; wt(EVT + 4);
    $display("Test failures and prewarn done");
    dm = 3'b001; rwake = 1'b1; wt(1); rwake = 1'b0; wt(3); dm = 3'b100;
    check_bit("wake_to_standby", w2s_seen, 1'b1);
    check_bit("regulator_switch_output", regsw, 1'b1);
    rd(7'h63, 8'h01, 8'h01);
    event_host_model_i.clear_seen(7'h63, v); wt(EVT + 4);
    shut = 1'b1; wt(3);
    check_bit("receiver_enable", rx_en, 1'b0);
    wpin = 1'b1; wt(3); wpin = 1'b0; wt(3); shut = 1'b0; wt(2);
    rd(7'h64, 8'hff, 8'h00);
    $display("Test sleep wake and overtemp done");
    spi_err = 3'b010; txd_to = 1'b1; wt(1); spi_err = 3'b000; txd_to = 1'b0; wt(3);
    rd(7'h61, 8'h02, 8'h02);
    rd(7'h63, 8'h10, 8'h10);
    event_host_model_i.clear_seen(7'h61, v);
    event_host_model_i.clear_seen(7'h63, v); wt(EVT + 4);
    bus_dom = 1'b1; wt(50);
    rd(7'h33, 8'h02, 8'h02);
    rd(7'h65, 8'h02, 8'h02);
    bus_dom = 1'b0;
    repeat (4) begin
      txd_rec = 1'b0; wt(1); txd_rec = 1'b1; wt(1);
    end
    wt(2);
    rd(7'h33, 8'h01, 8'h01);
    rd(7'h65, 8'hff, 8'h03);
    event_host_model_i.clear_seen(7'h65, v); wt(EVT + 4);
    check_bit("rxd_event_low", rxd_low, 1'b0);
    $display("Test serial and bus failures done");
    end_of_test;
  end
endmodule
bind event_capture event_capture_sva event_capture_sva_i (
  .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .device_mode_code(device_mode_code), .sleep_request(sleep_request),
  .sleep_granted(sleep_granted), .sleep_refused(sleep_refused),
  .wake_to_standby(wake_to_standby), .power_restored(power_restored),
  .vio_present(vio_present), .thermal_shutdown(thermal_shutdown),
  .transmitter_enable(transmitter_enable), .receiver_enable(receiver_enable),
  .rxd_event_low(rxd_event_low));
